// ---- i2c_ctrl_consts.vh ----
`ifndef I2C_CTRL_CONSTS_VH
`define I2C_CTRL_CONSTS_VH
// ****************************************
// register word offsets
// ****************************************
`define OFS_CONTROL 3'h0
`define OFS_RATE 3'h1
`define OFS_OWNADDR 3'h2
`define OFS_MASK 3'h3
`define OFS_STATUS 3'h4
// ****************************************
// control field positions
// ****************************************
`define BIT_ENABLE 15
`define BIT_IDLESTOP 13
`define BIT_RELEASE 12
`define BIT_STRICT 11
`define BIT_TENBIT 10
`define BIT_SLEWDIS 9
`define BIT_SMBUS 8
`define BIT_GENERAL_CALL_ENABLE 7
`define BIT_STRETCH 6
// ****************************************
// reset values
// ****************************************
`define RST_CONTROL 16'h1000
`define RST_RATE 16'h0002
`define RST_OWNADDR 10'h000
`define RST_MASK 10'h000
// ****************************************
// timing and codes
// ****************************************
`define RATE_OFFSET 2
`define HEADER_CODE 5'h1E
`define RSV_LOW 4'h0
`define RSV_HIGH 4'hF
`endif

// ---- baud_gen.v ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_consts.vh"
module baud_gen #(
  parameter RATE_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire run,
  input wire [RATE_W-1:0] divider,
  output reg sclGen
);
  reg [RATE_W:0] count_r;
  wire [RATE_W:0] reload;
  localparam [RATE_W:0] RELOAD_ADD = `RATE_OFFSET;
  // ****************************************
  // phase counter, each phase divider+2 cycles
  // ****************************************
  assign reload = {1'b0, divider} + RELOAD_ADD;
  always @(posedge clk)
  begin
    if (sys_rst || !run)
    begin
      count_r <= {(RATE_W+1){1'b0}};
      sclGen <= 1'b1;
    end
    else if (count_r <= {{RATE_W{1'b0}}, 1'b1})
    begin
      count_r <= reload;
      sclGen <= ~sclGen;
    end
    else
    begin
      count_r <= count_r - {{RATE_W{1'b0}}, 1'b1};
    end
  end
endmodule // baud_gen
`default_nettype wire

// ---- addr_match.v ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_consts.vh"
module addr_match (
  input wire [7:0] firstByte,
  input wire [7:0] secondByte,
  input wire secondPhase,
  input wire [9:0] ownAddr,
  input wire [9:0] mask,
  input wire tenBit,
  input wire strict,
  input wire gcEnable,
  output wire ack,
  output wire genCall,
  output wire headerHit
);
  wire [6:0] a7;
  wire [9:0] m;
  wire reserved;
  wire isHeader;
  wire exact7;
  wire masked7;
  wire lowHit;
  wire hit7;
  assign a7 = firstByte[7:1];
  assign m = strict ? 10'h000 : mask;
  assign reserved = (a7[6:3] == `RSV_LOW) || (a7[6:3] == `RSV_HIGH);
  assign isHeader = (a7[6:2] == `HEADER_CODE);
  assign exact7 = (a7 == ownAddr[6:0]);
  assign masked7 = ((a7 ^ ownAddr[6:0]) & ~m[6:0]) == 7'h00;
  // ****************************************
  // reserved filter: masked hits never count
  // ****************************************
  assign hit7 = reserved ? (!strict && exact7 && !isHeader) : masked7;
  assign genCall = (firstByte == 8'h00) && gcEnable;
  assign headerHit = tenBit && isHeader && (((a7[1:0] ^ ownAddr[9:8]) & ~m[9:8]) == 2'h0);
  assign lowHit = ((secondByte ^ ownAddr[7:0]) & ~m[7:0]) == 8'h00;
  assign ack = secondPhase ? (tenBit && lowHit) : (genCall || (tenBit ? headerHit : hit7));
endmodule // addr_match
`default_nettype wire

// ---- i2c_baud_address_control.v ----
// Overview of operation
// - serial clock is cycle clock over 2(div+2)
// - set mask bits make address bits don't-care
// - masking only while strict rule bit clear
// - reserved addresses never match through mask
// - reserved groups: 0000xxx and 1111xxx
// - general call acknowledged when enabled, or as exact own-address match (own address 0) in seven-bit mode while not strict
// - 11110xx matches only as ten-bit header
// - enable hands pins to serial logic
// - idle-stop bit halts block during idle
// - reset or disable sets clock release
// - release frees clock, zero holds it low
// - hardware clears release on tx start, and on rx end only while stretch is enabled
// - strict: slave refuses reserved addresses
// - not strict: reserved address exact match acked
// - address width bit picks seven or ten
// - slew bit turns slew limiting off
// - level bit selects bus-compliant input thresholds
// - general call accepted and flagged when enabled
// - stretch enable lets slave hold clock
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_consts.vh"
module i2c_baud_address_control #(
  parameter RATE_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire deviceIdle,
  input wire masterClkRun,
  input wire slaveTxStart,
  input wire slaveRxEnd,
  input wire addrValid,
  input wire [7:0] addrFirstByte,
  input wire [7:0] addrSecondByte,
  input wire addrSecondPhase,
  input wire sdaDriveLow,
  input wire sclIn,
  input wire sdaIn,
  output wire sclOut,
  output wire sclOe,
  output wire sdaOut,
  output wire sdaOe,
  input wire portSclOut,
  input wire portSclOe,
  input wire portSdaOut,
  input wire portSdaOe,
  output wire sclSync,
  output wire sdaSync,
  output reg addrAck,
  output reg genCallHit,
  output reg headerHit,
  output wire moduleActive,
  output wire slewLimitOn,
  output wire smbusLevels
);
  // ****************************************
  // register state
  // ****************************************
  reg enable_r;
  reg idleStop_r;
  reg release_r;
  reg release_nxt;
  reg strict_r;
  reg tenBit_r;
  reg slewDis_r;
  reg smbus_r;
  reg general_call_enable_r;
  reg stretch_r;
  reg [RATE_W-1:0] rate_r;
  reg [9:0] ownAddr_r;
  reg [9:0] mask_r;
  reg ackPhase_r;
  reg [1:0] sclMeta_r;
  reg [1:0] sdaMeta_r;
  reg sclLowSeen_r;
  wire [15:0] controlWord;
  wire [31:0] wdataMasked;
  wire req;
  wire doWrite;
  wire running;
  wire sclGen;
  wire holdScl;
  wire matchAck;
  wire matchGc;
  wire matchHeader;
  localparam [15:0] RST_CTL = `RST_CONTROL;
  // ****************************************
  // bus handshake, one wait cycle per access
  // ****************************************
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ackPhase_r;
  assign doWrite = avs_write && ackPhase_r;
  assign wdataMasked = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ackPhase_r <= 1'b0;
    end
    else
    begin
      ackPhase_r <= req && !ackPhase_r;
    end
  end
  // ****************************************
  // control word image
  // ****************************************
  assign controlWord = {enable_r, 1'b0, idleStop_r, release_r, strict_r, tenBit_r, slewDis_r,
    smbus_r, general_call_enable_r, stretch_r, 6'h00};
  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable_r <= RST_CTL[`BIT_ENABLE];
      idleStop_r <= RST_CTL[`BIT_IDLESTOP];
      strict_r <= RST_CTL[`BIT_STRICT];
      tenBit_r <= RST_CTL[`BIT_TENBIT];
      slewDis_r <= RST_CTL[`BIT_SLEWDIS];
      smbus_r <= RST_CTL[`BIT_SMBUS];
      general_call_enable_r <= RST_CTL[`BIT_GENERAL_CALL_ENABLE];
      stretch_r <= RST_CTL[`BIT_STRETCH];
      rate_r <= `RST_RATE;
      ownAddr_r <= `RST_OWNADDR;
      mask_r <= `RST_MASK;
    end
    else if (doWrite)
    begin
      case (avs_address)
        `OFS_CONTROL:
        begin
          if (avs_byteenable[1])
          begin
            enable_r <= avs_writedata[`BIT_ENABLE];
            idleStop_r <= avs_writedata[`BIT_IDLESTOP];
            strict_r <= avs_writedata[`BIT_STRICT];
            tenBit_r <= avs_writedata[`BIT_TENBIT];
            slewDis_r <= avs_writedata[`BIT_SLEWDIS];
            smbus_r <= avs_writedata[`BIT_SMBUS];
          end
          if (avs_byteenable[0])
          begin
            general_call_enable_r <= avs_writedata[`BIT_GENERAL_CALL_ENABLE];
            stretch_r <= avs_writedata[`BIT_STRETCH];
          end
        end
        `OFS_RATE:
        begin
          rate_r <= wdataMasked[RATE_W-1:0] | (rate_r & ~avs_byteenable_mask(avs_byteenable));
        end
        `OFS_OWNADDR:
        begin
          ownAddr_r <= wdataMasked[9:0] | (ownAddr_r & ~byteMask10(avs_byteenable));
        end
        `OFS_MASK:
        begin
          mask_r <= wdataMasked[9:0] | (mask_r & ~byteMask10(avs_byteenable));
        end
        default:
        begin
          mask_r <= mask_r;
        end
      endcase
    end
  end
  // ****************************************
  // byte lane helpers
  // ****************************************
  function [RATE_W-1:0] avs_byteenable_mask;
    input [3:0] be;
    reg [31:0] full;
    begin
      full = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      avs_byteenable_mask = full[RATE_W-1:0];
    end
  endfunction
  function [9:0] byteMask10;
    input [3:0] be;
    begin
      byteMask10 = {{2{be[1]}}, {8{be[0]}}};
    end
  endfunction
  // ****************************************
  // clock release bit
  // ****************************************
  always @*
  begin
    release_nxt = release_r;
    if (doWrite && avs_address == `OFS_CONTROL && avs_byteenable[1])
    begin
      release_nxt = avs_writedata[`BIT_RELEASE];
    end
    if (slaveTxStart || (slaveRxEnd && stretch_r))
    begin
      release_nxt = 1'b0;
    end
    if (!enable_r || (doWrite && avs_address == `OFS_CONTROL && avs_byteenable[1] &&
      !avs_writedata[`BIT_ENABLE]))
    begin
      release_nxt = 1'b1;
    end
  end
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      release_r <= RST_CTL[`BIT_RELEASE];
    end
    else
    begin
      release_r <= release_nxt;
    end
  end
  // ****************************************
  // pin input synchronisers
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclMeta_r <= 2'b11;
      sdaMeta_r <= 2'b11;
    end
    else
    begin
      sclMeta_r <= {sclMeta_r[0], sclIn};
      sdaMeta_r <= {sdaMeta_r[0], sdaIn};
    end
  end
  assign sclSync = sclMeta_r[1];
  assign sdaSync = sdaMeta_r[1];
  // ****************************************
  // stretch waits for next clock low
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst || release_r)
    begin
      sclLowSeen_r <= 1'b0;
    end
    else if (!sclSync)
    begin
      sclLowSeen_r <= 1'b1;
    end
  end
  assign holdScl = !release_r && (!stretch_r || sclLowSeen_r);
  // ****************************************
  // rate generator and run state
  // ****************************************
  assign running = enable_r && !(idleStop_r && deviceIdle);
  baud_gen #(
    .RATE_W(RATE_W)
  ) u_baud (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(running && masterClkRun),
    .divider(rate_r),
    .sclGen(sclGen)
  );
  // ****************************************
  // pin ownership
  // ****************************************
  assign moduleActive = running;
  assign sclOut = enable_r ? 1'b0 : portSclOut;
  assign sclOe = enable_r ? (running && (holdScl || (masterClkRun && !sclGen))) : portSclOe;
  assign sdaOut = enable_r ? 1'b0 : portSdaOut;
  assign sdaOe = enable_r ? (running && sdaDriveLow) : portSdaOe;
  assign slewLimitOn = !slewDis_r;
  assign smbusLevels = smbus_r;
  // ****************************************
  // slave address matcher
  // ****************************************
  addr_match u_match (
    .firstByte(addrFirstByte),
    .secondByte(addrSecondByte),
    .secondPhase(addrSecondPhase),
    .ownAddr(ownAddr_r),
    .mask(mask_r),
    .tenBit(tenBit_r),
    .strict(strict_r),
    .gcEnable(general_call_enable_r),
    .ack(matchAck),
    .genCall(matchGc),
    .headerHit(matchHeader)
  );
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      addrAck <= 1'b0;
      genCallHit <= 1'b0;
      headerHit <= 1'b0;
    end
    else
    begin
      addrAck <= addrValid && running && matchAck;
      genCallHit <= addrValid && running && matchGc && !addrSecondPhase;
      headerHit <= addrValid && running && matchHeader && !addrSecondPhase;
    end
  end
  // ****************************************
  // read data, captured in the wait cycle
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (avs_read && !ackPhase_r)
    begin
      case (avs_address)
        `OFS_CONTROL: avs_readdata <= {16'h0000, controlWord};
        `OFS_RATE: avs_readdata <= {{(32-RATE_W){1'b0}}, rate_r};
        `OFS_OWNADDR: avs_readdata <= {{22{1'b0}}, ownAddr_r};
        `OFS_MASK: avs_readdata <= {{22{1'b0}}, mask_r};
        `OFS_STATUS: avs_readdata <= {{26{1'b0}}, sdaSync, sclSync, sclLowSeen_r, holdScl, sclGen, running};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule // i2c_baud_address_control
`default_nettype wire

// ---- i2c_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic deviceIdle,
  input wire logic addrValid,
  input wire logic [7:0] addrFirstByte,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic portSclOut,
  input wire logic portSclOe,
  input wire logic portSdaOut,
  input wire logic portSdaOe,
  input wire logic addrAck,
  input wire logic genCallHit,
  input wire logic headerHit,
  input wire logic moduleActive,
  input wire logic slewLimitOn,
  input wire logic smbusLevels
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ****
  // bus and pins
  // ****
  property p_wait;
    $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  property p_offPins;
    !moduleActive && !deviceIdle |-> {sclOe, sclOut, sdaOe, sdaOut} == {portSclOe, portSclOut, portSdaOe, portSdaOut};
  endproperty
  a_offPins: assert property (p_offPins) else $error("port pass-through wrong");
  property p_onPins;
    moduleActive |-> !sclOut && !sdaOut;
  endproperty
  a_onPins: assert property (p_onPins) else $error("pin drives high");
  property p_cfg;
    !avs_write |=> $stable(slewLimitOn) && $stable(smbusLevels);
  endproperty
  a_cfg: assert property (p_cfg) else $error("pad select moved");
  // ****
  // address matcher
  // ****
  property p_refuse;
    addrValid && !moduleActive |=> !addrAck && !genCallHit && !headerHit;
  endproperty
  a_refuse: assert property (p_refuse) else $error("match while halted");
  property p_gc;
    genCallHit |-> addrAck && $past(addrValid) && $past(addrFirstByte) == 8'h00;
  endproperty
  a_gc: assert property (p_gc) else $error("general call wrong");
  property p_hdr;
    headerHit |-> $past(addrValid) && $past(addrFirstByte[7:3]) == 5'h1E;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header hit wrong");
  property p_ack;
    addrAck |-> $past(addrValid) && $past(moduleActive) ##1 !addrAck;
  endproperty
  a_ack: assert property (p_ack) else $error("ack pulse wrong");
  c_ack: cover property (addrAck);
  c_gc: cover property (genCallHit);
  c_hdr: cover property (headerHit);
endmodule // i2c_ctrl_chk
`default_nettype wire

// ---- i2c_bus_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_peer (
  input wire logic sclOe,
  input wire logic sclOut,
  input wire logic sdaOe,
  input wire logic sdaOut,
  input wire logic peerSclLow,
  output logic sclIn,
  output logic sdaIn
);
  // ****
  // open-drain wires, pulled up
  // ****
  assign sclIn = !(sclOe && !sclOut) && !peerSclLow;
  assign sdaIn = !(sdaOe && !sdaOut);
endmodule // i2c_bus_peer
`default_nettype wire

// ---- i2c_baud_address_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_consts.vh"
module i2c_baud_address_control_bench;
  logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, deviceIdle = 0, masterClkRun = 0;
  logic slaveTxStart = 0, slaveRxEnd = 0, addrValid = 0, addrSecondPhase = 0, sdaDriveLow = 0;
  logic portSclOut = 0, portSclOe = 0, portSdaOut = 0, portSdaOe = 0, peerSclLow = 0;
  logic [2:0] avs_address = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 0, rd;
  logic [7:0] addrFirstByte = 0, addrSecondByte = 0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, sclIn, sdaIn, sclOut, sclOe, sdaOut, sdaOe, sclSync, sdaSync;
  wire logic addrAck, genCallHit, headerHit, moduleActive, slewLimitOn, smbusLevels;
  int fails = 0, comparisons = 0, t = 0;
  i2c_baud_address_control DUT (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .deviceIdle(deviceIdle), .masterClkRun(masterClkRun),
    .slaveTxStart(slaveTxStart), .slaveRxEnd(slaveRxEnd), .addrValid(addrValid), .addrFirstByte(addrFirstByte),
    .addrSecondByte(addrSecondByte), .addrSecondPhase(addrSecondPhase), .sdaDriveLow(sdaDriveLow),
    .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .portSclOut(portSclOut), .portSclOe(portSclOe), .portSdaOut(portSdaOut), .portSdaOe(portSdaOe),
    .sclSync(sclSync), .sdaSync(sdaSync), .addrAck(addrAck), .genCallHit(genCallHit), .headerHit(headerHit),
    .moduleActive(moduleActive), .slewLimitOn(slewLimitOn), .smbusLevels(smbusLevels)
  );
  i2c_bus_peer PEER (
    .sclOe(sclOe), .sclOut(sclOut), .sdaOe(sdaOe), .sdaOut(sdaOut), .peerSclLow(peerSclLow),
    .sclIn(sclIn), .sdaIn(sdaIn)
  );
  initial forever #10 clk = ~clk;
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [2:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rd, e);
  endtask
  task automatic adr(input logic [7:0] f, s, input logic ph, input logic [2:0] m, e);
    addrFirstByte <= f;
    addrSecondByte <= s;
    addrSecondPhase <= ph;
    addrValid <= 1;
    @(posedge clk);
    addrValid <= 0;
    #1 chk({addrAck, genCallHit, headerHit} & m, e);
    @(posedge clk);
  endtask
  task automatic pulse(input logic k);
    slaveTxStart <= !k;
    slaveRxEnd <= k;
    @(posedge clk);
    slaveTxStart <= 0;
    slaveRxEnd <= 0;
  endtask
  task automatic run(input logic v, output int c);
    c = 0;
    while (sclOe === v && c < 99)
    begin
      @(posedge clk);
      c++;
    end
  endtask
  function automatic logic [2:0] exp7(logic [7:0] f, logic [6:0] o, m, logic s, g);
    logic [6:0] a;
    a = f[7:1];
    if (f == 8'h00 && g) return 3'h6;
    if (a[6:3] == 4'h0 || a[6:3] == 4'hF) return {!s && a == o, 2'h0};
    return {s ? a == o : ((a ^ o) & ~m) == 7'h00, 2'h0};
  endfunction
  task endt;
    t++;
    $display("test %0d done", t);
  endtask
  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fails++;
    finish_test;
  end
  // ****
  // tests
  // ****
  initial
  begin
    logic [6:0] o, m;
    logic [7:0] f;
    logic s, g;
    int d, n, hi, lo;
    void'($urandom(32'h729CA01C));
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rc(0, `RST_CONTROL);
    rc(1, `RST_RATE);
    rc(2, 0);
    rc(3, 0);
    rc(4, 32'h00000032);
    bus(1, 5, 32'hFFFF);
    rc(5, 0);
    repeat (8)
    begin
      {portSclOe, portSclOut, portSdaOe, portSdaOut} <= 4'($urandom);
      @(posedge clk);
      #1 chk({sclOe, sclOut, sdaOe, sdaOut}, {portSclOe, portSclOut, portSdaOe, portSdaOut});
      @(posedge clk);
    end
    endt;
    bus(1, 0, 32'h9000);
    bus(1, 0, 32'h8000);
    repeat (4) @(posedge clk);
    chk(sclOe, 1);
    bus(1, 0, 0);
    rc(0, 32'h1000);
    bus(1, 0, 32'h9040);
    bus(1, 0, 32'h8040);
    repeat (4) @(posedge clk);
    chk(sclOe, 0);
    peerSclLow <= 1;
    repeat (4) @(posedge clk);
    peerSclLow <= 0;
    repeat (4) @(posedge clk);
    chk(sclOe, 1);
    bus(1, 0, 32'h9000);
    repeat (4) @(posedge clk);
    chk(sclOe, 0);
    sdaDriveLow <= 1;
    repeat (3) @(posedge clk);
    chk(sdaOe, 1);
    repeat (2) @(posedge clk);
    chk({sclSync, sdaSync}, 2'h2);
    sdaDriveLow <= 0;
    pulse(0);
    rc(0, 32'h8000);
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rc(0, `RST_CONTROL);
    bus(1, 0, 32'h9040);
    pulse(1);
    rc(0, 32'h8040);
    bus(1, 0, 32'h9000);
    pulse(1);
    rc(0, 32'h9000);
    for (int k = 0; k < 4; k++)
    begin
      bus(1, 0, 32'h9000 | (k << 8));
      chk({slewLimitOn, smbusLevels}, {~k[1], k[0]});
    end
    endt;
    bus(1, 0, 32'hB000);
    deviceIdle <= 1;
    bus(1, 2, 32'h30);
    adr(8'h60, 0, 0, 3'h7, 0);
    chk(moduleActive, 0);
    bus(1, 0, 32'h9000);
    adr(8'h60, 0, 0, 3'h7, 3'h4);
    deviceIdle <= 0;
    bus(1, 2, 32'h2A5);
    bus(1, 0, 32'h9400);
    adr(8'hF4, 0, 0, 3'h1, 3'h1);
    adr(8'hF4, 8'hA5, 1, 3'h4, 3'h4);
    adr(8'hF4, 8'hA4, 1, 3'h4, 0);
    bus(1, 3, 32'h1);
    adr(8'hF4, 8'hA4, 1, 3'h4, 3'h4);
    bus(1, 3, 0);
    bus(1, 2, 32'h7A);
    bus(1, 0, 32'h9000);
    adr(8'hF4, 0, 0, 3'h7, 0);
    bus(1, 2, 32'h05);
    adr(8'h0A, 0, 0, 3'h7, 3'h4);
    bus(1, 0, 32'h9800);
    adr(8'h0A, 0, 0, 3'h7, 0);
    bus(1, 2, 32'h10);
    bus(1, 3, 32'h1F);
    bus(1, 0, 32'h9000);
    adr(8'h0A, 0, 0, 3'h7, 0);
    adr(8'h00, 0, 0, 3'h7, 0);
    bus(1, 0, 32'h9880);
    adr(8'h00, 0, 0, 3'h7, 3'h6);
    endt;
    for (int i = 0; i < 40; i++)
    begin
      o = 7'h10 + 7'($urandom % 96);
      m = (i % 4 == 0) ? 7'h00 : 7'($urandom);
      {s, g} = 2'($urandom);
      f = 8'($urandom);
      if (i % 2) f[7:1] = o ^ (m & 7'($urandom));
      if (i % 10 == 3) f = 8'h00;
      bus(1, 2, o);
      bus(1, 3, m);
      bus(1, 0, 32'h9000 | (s << 11) | (g << 7));
      adr(f, 8'($urandom), 0, 3'h7, exp7(f, o, m, s, g));
    end
    endt;
    bus(1, 0, 32'h9000);
    masterClkRun <= 1;
    for (int j = 0; j < 2; j++)
    begin
      d = j ? 2 + $urandom % 8 : 2;
      bus(1, 1, d);
      run(1, n);
      run(0, n);
      run(1, hi);
      run(0, lo);
      chk(hi, d + 2);
      chk(lo, d + 2);
    end
    masterClkRun <= 0;
    endt;
    finish_test;
  end
endmodule // i2c_baud_address_control_bench
bind i2c_baud_address_control i2c_ctrl_chk CHK (
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .deviceIdle(deviceIdle), .addrValid(addrValid), .addrFirstByte(addrFirstByte), .sclOut(sclOut), .sclOe(sclOe),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .portSclOut(portSclOut), .portSclOe(portSclOe), .portSdaOut(portSdaOut),
  .portSdaOe(portSdaOe), .addrAck(addrAck), .genCallHit(genCallHit), .headerHit(headerHit),
  .moduleActive(moduleActive), .slewLimitOn(slewLimitOn), .smbusLevels(smbusLevels)
);
`default_nettype wire
